// ==== eq_adapt_port.sv ====
`timescale 1ns/10ps
`include "rx_eq_cfg.svh"

module eq_adapt_port #(
  parameter int unsigned WAIT_BASE_CYCLES = `EQ_WAIT_BASE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic lock_raw_i,
  input wire logic [2:0] wait_code_i,
  input wire logic first_zero_i,
  input wire logic restart_i,
  input wire logic floor_en_i,
  input wire logic [3:0] floor_val_i,
  input wire logic [3:0] upper_i,
  input wire logic bypass_i,
  input wire logic [5:0] manual_i,
  input wire logic lock_mode_i,
  output logic [5:0] eq_setting_o,
  output logic rx_lock_o,
  output logic [2:0] state_low_o,
  output logic [2:0] state_high_o
);

  rx_eq_pkg::eq_port_state_t cur_ff;
  rx_eq_pkg::eq_port_state_t nxt_cur;
  logic [`EQ_WAIT_CNT_W-1:0] wait_limit;
  logic [3:0] start_idx;

  always_comb begin
    nxt_cur = cur_ff;
    wait_limit = `EQ_WAIT_CNT_W'(WAIT_BASE_CYCLES) << wait_code_i;
    start_idx = floor_en_i ? floor_val_i : 4'h0;
    nxt_cur.lock_sync = {cur_ff.lock_sync[1:0], lock_raw_i};
    if (cur_ff.lock_sync[2] == cur_ff.lock_sync[1]) begin
      nxt_cur.lock_f = cur_ff.lock_sync[1];
    end
    if (bypass_i) begin
      nxt_cur.fsm = rx_eq_pkg::EQ_BYPASS;
      nxt_cur.done = 1'b1;
    end else if (restart_i) begin
      nxt_cur.fsm = rx_eq_pkg::EQ_SEEK;
      nxt_cur.idx = start_idx;
      nxt_cur.cnt = '0;
      nxt_cur.done = 1'b0;
    end else begin
      case (cur_ff.fsm)
        rx_eq_pkg::EQ_IDLE: begin
          nxt_cur.fsm = rx_eq_pkg::EQ_SEEK;
          nxt_cur.idx = start_idx;
          nxt_cur.cnt = '0;
        end
        rx_eq_pkg::EQ_SEEK: begin
          if (cur_ff.lock_f) begin
            if (first_zero_i && !cur_ff.first_seen) begin
              nxt_cur.first_seen = 1'b1;
              nxt_cur.idx = 4'h0;
              nxt_cur.cnt = '0;
            end else begin
              nxt_cur.first_seen = 1'b1;
              nxt_cur.fsm = rx_eq_pkg::EQ_LOCKED;
              nxt_cur.done = 1'b1;
            end
          end else if (cur_ff.cnt >= wait_limit - `EQ_WAIT_CNT_W'(1)) begin
            nxt_cur.cnt = '0;
            nxt_cur.idx = (cur_ff.idx >= upper_i) ? start_idx : cur_ff.idx + 4'h1;
          end else begin
            nxt_cur.cnt = cur_ff.cnt + `EQ_WAIT_CNT_W'(1);
          end
        end
        rx_eq_pkg::EQ_LOCKED: begin
          if (!cur_ff.lock_f) begin
            nxt_cur.fsm = rx_eq_pkg::EQ_SEEK;
            nxt_cur.done = 1'b0;
            nxt_cur.cnt = '0;
          end
        end
        rx_eq_pkg::EQ_BYPASS: begin
          nxt_cur.fsm = rx_eq_pkg::EQ_IDLE;
          nxt_cur.done = 1'b0;
        end
        default: begin
          nxt_cur.fsm = rx_eq_pkg::EQ_IDLE;
        end
      endcase
    end
    nxt_cur.eq_set = bypass_i ? manual_i : {2'b00, nxt_cur.idx};
    nxt_cur.lock_out = lock_mode_i ? (nxt_cur.lock_f & nxt_cur.done) : nxt_cur.lock_f;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign eq_setting_o = cur_ff.eq_set;
  assign rx_lock_o = cur_ff.lock_out;
  assign state_low_o = cur_ff.fsm;
  assign state_high_o = cur_ff.idx[2:0];

endmodule

// ==== rx_eq_cfg.svh ====
`ifndef RX_EQ_CFG_SVH
`define RX_EQ_CFG_SVH

`define CLK_PERIOD_NS 10
`define EQ_WAIT_BASE_NS 164000
`define EQ_WAIT_BASE_CYCLES (`EQ_WAIT_BASE_NS / `CLK_PERIOD_NS)
`define EQ_WAIT_CNT_W 22
`define NUM_PORTS 4

`define ADDR_PORT_SEL 8'h4C
`define ADDR_RSVD_BF 8'hBF
`define ADDR_RSVD_LO 8'hC0
`define ADDR_RSVD_HI 8'hCF
`define ADDR_PORT_DEBUG 8'hD0
`define ADDR_RSVD_D1 8'hD1
`define ADDR_EQ_CTL2 8'hD2
`define ADDR_EQ_STATUS 8'hD3
`define ADDR_EQ_BYPASS 8'hD4
`define ADDR_EQ_MINMAX 8'hD5

`define RSVD_D1_VALUE 8'h43
`define PORT_SEL_RESET 8'h01
`define EQ_CTL2_RESET 8'h94
`define EQ_CTL2_WMASK 8'hF4
`define EQ_BYPASS_RESET 8'h60
`define EQ_MINMAX_RESET 8'hF2

`define SEL_RD_MSB 5
`define SEL_RD_LSB 4
`define SEL_WR_MSB 3
`define DBG_SELFTEST_BIT 5
`define DBG_CONT_BIT 1
`define DBG_SINGLE_BIT 0
`define CTL2_WAIT_MSB 7
`define CTL2_WAIT_LSB 5
`define CTL2_FIRST_BIT 4
`define CTL2_RESTART_BIT 3
`define CTL2_FLOOR_BIT 2
`define BYP_UPPER_MSB 7
`define BYP_UPPER_LSB 5
`define BYP_LOCKMODE_BIT 4
`define BYP_LOWER_MSB 3
`define BYP_LOWER_LSB 1
`define BYP_DISABLE_BIT 0
`define MM_LIMIT_MSB 7
`define MM_LIMIT_LSB 4
`define MM_FLOOR_MSB 3

`endif

// ==== rx_eq_pkg.sv ====
`include "rx_eq_cfg.svh"

package rx_eq_pkg;

  typedef enum logic [2:0] {
    EQ_IDLE = 3'b000,
    EQ_SEEK = 3'b001,
    EQ_LOCKED = 3'b010,
    EQ_BYPASS = 3'b011
  } eq_fsm_t;

  typedef struct packed {
    eq_fsm_t fsm;
    logic [`EQ_WAIT_CNT_W-1:0] cnt;
    logic [3:0] idx;
    logic first_seen;
    logic done;
    logic [2:0] lock_sync;
    logic lock_f;
    logic [5:0] eq_set;
    logic lock_out;
  } eq_port_state_t;

  typedef struct packed {
    logic [1:0] rd_sel;
    logic [3:0] wr_en;
    logic [3:0] dbg_cont;
    logic [3:0][7:0] ctl2;
    logic [3:0][7:0] bypass;
    logic [3:0][7:0] minmax;
    logic [3:0] restart;
    logic [3:0] inject;
    logic [3:0] st_s1;
    logic [3:0] st_s2;
    logic [3:0] st_s3;
    logic [3:0] st_f;
    logic [7:0] rdata;
  } regs_state_t;

endpackage

// ==== rx_port_equalizer_debug_regs.sv ====
// Summary of operation
// - read-select bits pick paged port
// - write-enable bits steer paged writes
// - remote self-test flag readable
// - continuous back-channel error corruption
// - single error injection, self-clearing
// - lock wait time doubles per code
// - first lock may restart at zero
// - restart bit restarts adaptation, self-clears
// - floor enable selects floor start
// - floor value field sets start point
// - upper limit caps equalizer setting
// - two read-only status fields, reset zero
// - bypass bit disables adaptation
// - manual six-bit setting when bypassed
// - lock mode waits for adaptation
// - reserved locations read fixed values
`timescale 1ns/10ps
`include "rx_eq_cfg.svh"

module rx_port_equalizer_debug_regs #(
  parameter int unsigned WAIT_BASE_CYCLES = `EQ_WAIT_BASE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [3:0] rx_lock_raw_i,
  input wire logic [3:0] remote_selftest_i,
  output logic [3:0] bc_error_inject_o,
  output logic [3:0][5:0] eq_setting_o,
  output logic [3:0] rx_lock_o
);

  localparam rx_eq_pkg::regs_state_t REGS_RESET = '{
    rd_sel: 2'(`PORT_SEL_RESET >> `SEL_RD_LSB),
    wr_en: 4'(`PORT_SEL_RESET),
    dbg_cont: 4'h0,
    ctl2: {`NUM_PORTS{`EQ_CTL2_RESET}},
    bypass: {`NUM_PORTS{`EQ_BYPASS_RESET}},
    minmax: {`NUM_PORTS{`EQ_MINMAX_RESET}},
    restart: 4'h0,
    inject: 4'h0,
    st_s1: 4'h0,
    st_s2: 4'h0,
    st_s3: 4'h0,
    st_f: 4'h0,
    rdata: 8'h00
  };

  rx_eq_pkg::regs_state_t state_ff;
  rx_eq_pkg::regs_state_t nxt_state;
  logic [3:0] single_err;
  logic [3:0][2:0] status_low;
  logic [3:0][2:0] status_high;
  logic [7:0] sel_ctl2;
  logic [7:0] sel_bypass;
  logic [7:0] sel_minmax;
  logic [5:0] sel_status;

  // paged view of the port chosen for reads
  // read port select
  assign sel_ctl2 = state_ff.ctl2[state_ff.rd_sel];
  assign sel_bypass = state_ff.bypass[state_ff.rd_sel];
  assign sel_minmax = state_ff.minmax[state_ff.rd_sel];
  assign sel_status = {status_high[state_ff.rd_sel], status_low[state_ff.rd_sel]};

  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    eq_adapt_port #(
      .WAIT_BASE_CYCLES(WAIT_BASE_CYCLES)
    ) u_eq (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .lock_raw_i(rx_lock_raw_i[p]),
      .wait_code_i(state_ff.ctl2[p][`CTL2_WAIT_MSB:`CTL2_WAIT_LSB]),
      .first_zero_i(state_ff.ctl2[p][`CTL2_FIRST_BIT]),
      .restart_i(state_ff.restart[p]),
      .floor_en_i(state_ff.ctl2[p][`CTL2_FLOOR_BIT]),
      .floor_val_i(state_ff.minmax[p][`MM_FLOOR_MSB:0]),
      .upper_i(state_ff.minmax[p][`MM_LIMIT_MSB:`MM_LIMIT_LSB]),
      .bypass_i(state_ff.bypass[p][`BYP_DISABLE_BIT]),
      .manual_i({state_ff.bypass[p][`BYP_UPPER_MSB:`BYP_UPPER_LSB],
                 state_ff.bypass[p][`BYP_LOWER_MSB:`BYP_LOWER_LSB]}),
      .lock_mode_i(state_ff.bypass[p][`BYP_LOCKMODE_BIT]),
      .eq_setting_o(eq_setting_o[p]),
      .rx_lock_o(rx_lock_o[p]),
      .state_low_o(status_low[p]),
      .state_high_o(status_high[p])
    );
  end

  always_comb begin
    nxt_state = state_ff;
    single_err = 4'h0;
    nxt_state.restart = 4'h0;
    // remote self-test pins: three-stage sync, change on agreement
    nxt_state.st_s1 = remote_selftest_i;
    nxt_state.st_s2 = state_ff.st_s1;
    nxt_state.st_s3 = state_ff.st_s2;
    nxt_state.st_f = (state_ff.st_s2 & ~(state_ff.st_s2 ^ state_ff.st_s3)) |
                     (state_ff.st_f & (state_ff.st_s2 ^ state_ff.st_s3));
    if (reg_wr_i) begin
      if (reg_addr_i == `ADDR_PORT_SEL) begin
        nxt_state.rd_sel = reg_wdata_i[`SEL_RD_MSB:`SEL_RD_LSB];
        nxt_state.wr_en = reg_wdata_i[`SEL_WR_MSB:0];
      end else begin
        for (int p = 0; p < `NUM_PORTS; p++) begin
          // only enabled ports take the write
          if (state_ff.wr_en[p]) begin
            if (reg_addr_i == `ADDR_PORT_DEBUG) begin
              nxt_state.dbg_cont[p] = reg_wdata_i[`DBG_CONT_BIT];
              single_err[p] = reg_wdata_i[`DBG_SINGLE_BIT];
            end else if (reg_addr_i == `ADDR_EQ_CTL2) begin
              nxt_state.ctl2[p] = reg_wdata_i & `EQ_CTL2_WMASK;
              nxt_state.restart[p] = reg_wdata_i[`CTL2_RESTART_BIT];
            end else if (reg_addr_i == `ADDR_EQ_BYPASS) begin
              nxt_state.bypass[p] = reg_wdata_i;
            end else if (reg_addr_i == `ADDR_EQ_MINMAX) begin
              nxt_state.minmax[p] = reg_wdata_i;
            end
          end
        end
      end
    end
    // continuous level or one-cycle error pulse
    nxt_state.inject = nxt_state.dbg_cont | single_err;
    if (reg_rd_i) begin
      if (reg_addr_i == `ADDR_PORT_SEL) begin
        nxt_state.rdata = {2'b00, state_ff.rd_sel, state_ff.wr_en};
      end else if (reg_addr_i == `ADDR_PORT_DEBUG) begin
        nxt_state.rdata = 8'h00;
        nxt_state.rdata[`DBG_SELFTEST_BIT] = state_ff.st_f[state_ff.rd_sel];
        nxt_state.rdata[`DBG_CONT_BIT] = state_ff.dbg_cont[state_ff.rd_sel];
      end else if (reg_addr_i == `ADDR_RSVD_D1) begin
        nxt_state.rdata = `RSVD_D1_VALUE;
      end else if (reg_addr_i == `ADDR_EQ_CTL2) begin
        nxt_state.rdata = sel_ctl2;
      end else if (reg_addr_i == `ADDR_EQ_STATUS) begin
        // status fields from the adaptation engine
        nxt_state.rdata = {2'b00, sel_status};
      end else if (reg_addr_i == `ADDR_EQ_BYPASS) begin
        nxt_state.rdata = sel_bypass;
      end else if (reg_addr_i == `ADDR_EQ_MINMAX) begin
        nxt_state.rdata = sel_minmax;
      end else if (reg_addr_i == `ADDR_RSVD_BF ||
                   (reg_addr_i >= `ADDR_RSVD_LO && reg_addr_i <= `ADDR_RSVD_HI)) begin
        nxt_state.rdata = 8'h00;
      end else begin
        nxt_state.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= REGS_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata_o = state_ff.rdata;
  assign bc_error_inject_o = state_ff.inject;

  // checks
  logic wr_dbg0;
  logic wr_ctl2_0;
  logic [3:0][7:0] bypass_all;
  assign wr_dbg0 = reg_wr_i && reg_addr_i == `ADDR_PORT_DEBUG && state_ff.wr_en[0];
  assign wr_ctl2_0 = reg_wr_i && reg_addr_i == `ADDR_EQ_CTL2 && state_ff.wr_en[0];
  assign bypass_all = state_ff.bypass;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_single_inject: assert property (
    wr_dbg0 && reg_wdata_i[`DBG_SINGLE_BIT] && !reg_wdata_i[`DBG_CONT_BIT]
    |=> bc_error_inject_o[0] ##1 (bc_error_inject_o[0] == $past(wr_dbg0)))
    else $error("single error pulse wrong length");

  a_cont_hold: assert property (
    state_ff.dbg_cont[0] && !wr_dbg0 |=> bc_error_inject_o[0])
    else $error("continuous error injection dropped");

  a_inject_quiet: assert property (
    !state_ff.dbg_cont[0] && !wr_dbg0 |=> !bc_error_inject_o[0])
    else $error("error injected without request");

  a_restart_pulse: assert property (
    wr_ctl2_0 && reg_wdata_i[`CTL2_RESTART_BIT] ##1 !wr_ctl2_0
    |-> state_ff.restart[0] ##1 !state_ff.restart[0])
    else $error("restart not a single pulse");

  a_restart_readzero: assert property (
    reg_rd_i && reg_addr_i == `ADDR_EQ_CTL2 |=> !reg_rdata_o[`CTL2_RESTART_BIT])
    else $error("restart bit did not self clear");

  a_paged_read: assert property (
    reg_rd_i && reg_addr_i == `ADDR_EQ_BYPASS |=> reg_rdata_o == $past(sel_bypass))
    else $error("paged read returned wrong port");

  a_no_port_write: assert property (
    reg_wr_i && reg_addr_i == `ADDR_EQ_BYPASS && state_ff.wr_en == 4'h0
    |=> $stable(bypass_all))
    else $error("write landed with no port enabled");

  a_rsvd_zero: assert property (
    reg_rd_i && reg_addr_i >= `ADDR_RSVD_LO && reg_addr_i <= `ADDR_RSVD_HI
    |=> reg_rdata_o == 8'h00)
    else $error("reserved block read nonzero");

  a_rsvd_d1: assert property (
    reg_rd_i && reg_addr_i == `ADDR_RSVD_D1 |=> reg_rdata_o == `RSVD_D1_VALUE)
    else $error("reserved location lost its default");

  a_status_upper: assert property (
    reg_rd_i && reg_addr_i == `ADDR_EQ_STATUS |=> reg_rdata_o[7:6] == 2'b00)
    else $error("status reserved bits nonzero");

  a_bypass_manual: assert property (
    state_ff.bypass[0][`BYP_DISABLE_BIT] && $stable(bypass_all)
    |=> eq_setting_o[0] == {$past(bypass_all[0][`BYP_UPPER_MSB:`BYP_UPPER_LSB]),
                            $past(bypass_all[0][`BYP_LOWER_MSB:`BYP_LOWER_LSB])})
    else $error("manual equalizer setting not applied");

  a_selftest_flag: assert property (
    remote_selftest_i[0] [*5] ##1 reg_rd_i && reg_addr_i == `ADDR_PORT_DEBUG &&
    state_ff.rd_sel == 2'b00 |=> reg_rdata_o[`DBG_SELFTEST_BIT])
    else $error("remote self-test flag not reported");

  c_single_inject: cover property (wr_dbg0 && reg_wdata_i[`DBG_SINGLE_BIT]);
  c_port3_read: cover property (reg_rd_i && state_ff.rd_sel == 2'b11);
  c_bypass_on: cover property (state_ff.bypass[0][`BYP_DISABLE_BIT]);
  c_lock_seen: cover property (rx_lock_o[0]);

endmodule

// ==== rx_port_equalizer_debug_regs_bench.sv ====
`timescale 1ns/10ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module rx_port_equalizer_debug_regs_bench;
  localparam int unsigned base_cyc = 4;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] exp;
  } row_t;
  logic ref_clk_i;
  logic rst_n_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic [3:0] rx_lock_raw_i;
  logic [3:0] remote_selftest_i;
  logic [3:0] bc_error_inject_o;
  logic [3:0][5:0] eq_setting_o;
  logic [3:0] rx_lock_o;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] rv;
  logic [5:0] mx;
  row_t rows [11];

  rx_port_equalizer_debug_regs #(.WAIT_BASE_CYCLES(base_cyc)) dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .rx_lock_raw_i(rx_lock_raw_i),
    .remote_selftest_i(remote_selftest_i),
    .bc_error_inject_o(bc_error_inject_o),
    .eq_setting_o(eq_setting_o),
    .rx_lock_o(rx_lock_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic do_reset();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // cycles between two changes of port 0 setting
  task automatic step_period(output int p);
    logic [5:0] s;
    int k;
    k = 0;
    #1;
    s = eq_setting_o[0];
    while (eq_setting_o[0] === s && k < 3000) begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    s = eq_setting_o[0];
    p = 0;
    while (eq_setting_o[0] === s && p < 3000) begin
      @(posedge ref_clk_i);
      #1;
      p++;
    end
  endtask

  initial begin
    rst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    rx_lock_raw_i = 4'h0;
    remote_selftest_i = 4'h0;
    rows = '{'{8'h4C, 8'h01}, '{8'hD0, 8'h00}, '{8'hD1, 8'h43}, '{8'hD2, 8'h94},
             '{8'hD4, 8'h60}, '{8'hD5, 8'hF2}, '{8'hBF, 8'h00}, '{8'hC0, 8'h00},
             '{8'hC7, 8'h00}, '{8'hCF, 8'h00}, '{8'h10, 8'h00}};
    do_reset();
    // reset values and fixed reserved readback
    foreach (rows[i]) begin
      rd(rows[i].addr, rv);
      `CHK(rv, rows[i].exp)
    end
    // each port gets its own manual lower bits
    for (int p = 0; p < 4; p++) begin
      wr(8'h4C, 8'h01 << p);
      wr(8'hD4, 8'h60 | (8'(p) << 1));
    end
    for (int p = 0; p < 4; p++) begin
      wr(8'h4C, 8'(p) << 4);
      rd(8'hD4, rv);
      `CHK(rv, 8'h60 | (8'(p) << 1))
    end
    // no write enable: write lost
    wr(8'h4C, 8'h00);
    wr(8'hD4, 8'hFF);
    rd(8'hD4, rv);
    `CHK(rv, 8'h60)
    wr(8'h4C, 8'h01);
    wr(8'hD0, 8'h01);
    #1;
    `CHK(bc_error_inject_o, 4'h1)
    @(posedge ref_clk_i);
    #1;
    `CHK(bc_error_inject_o, 4'h0)
    rd(8'hD0, rv);
    `CHK(rv, 8'h00)
    wr(8'hD0, 8'h02);
    repeat (5) @(posedge ref_clk_i);
    #1;
    `CHK(bc_error_inject_o, 4'h1)
    rd(8'hD0, rv);
    `CHK(rv, 8'h02)
    wr(8'hD0, 8'h00);
    remote_selftest_i <= 4'h1;
    repeat (5) @(posedge ref_clk_i);
    rd(8'hD0, rv);
    `CHK(rv, 8'h20)
    wr(8'h4C, 8'h11);
    rd(8'hD0, rv);
    `CHK(rv, 8'h00)
    wr(8'h4C, 8'h01);
    // bypass with manual setting 101_101
    wr(8'hD4, 8'hAB);
    repeat (5) @(posedge ref_clk_i);
    #1;
    `CHK(eq_setting_o[0], 6'h2D)
    rd(8'hD3, rv);
    `CHK(rv[2:0], 3'h3)
    wr(8'hD4, 8'h60);
    // floor start then zero start
    wr(8'hD5, 8'hF5);
    wr(8'hD2, 8'h9C);
    repeat (4) @(posedge ref_clk_i);
    #1;
    `CHK(eq_setting_o[0], 6'h05)
    wr(8'hD2, 8'h98);
    repeat (4) @(posedge ref_clk_i);
    #1;
    `CHK(eq_setting_o[0], 6'h00)
    wr(8'hD5, 8'h30);
    for (int c = 0; c < 3; c++) begin
      wr(8'hD2, {3'(c), 5'h18});
      step_period(n);
      `CHK(n, base_cyc << c)
    end
    wr(8'hD2, 8'h18);
    mx = 6'h00;
    repeat (60) begin
      @(posedge ref_clk_i);
      #1;
      if (eq_setting_o[0] > mx) mx = eq_setting_o[0];
    end
    `CHK(mx, 6'h03)
    // lock follows the circuit alone in mode 0
    rx_lock_raw_i <= 4'h1;
    repeat (6) @(posedge ref_clk_i);
    #1;
    `CHK(rx_lock_o, 4'h1)
    rx_lock_raw_i <= 4'h0;
    do_reset();
    wr(8'hD4, 8'h70);
    wr(8'hD2, 8'hF4);
    rx_lock_raw_i <= 4'h1;
    // filtered lock seen: index forced to zero, lock still held back
    repeat (5) @(posedge ref_clk_i);
    #1;
    `CHK(eq_setting_o[0], 6'h00)
    `CHK(rx_lock_o[0], 1'b0)
    n = 0;
    while (rx_lock_o[0] !== 1'b1 && n < 1500) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    `CHK(rx_lock_o[0], 1'b1)
    stop_test();
  end
endmodule
